// *** verif/mioes_event_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// far side: credit logic raising event levels for a burst of cycles
// ----------------------------------------------------------------
module mioes_event_source (
    input wire logic core_clk_i,
    input wire logic go_i,
    input wire mioes_pkg::mioes_events_t pattern_i,
    input wire logic [7:0] len_i,
    output mioes_pkg::mioes_events_t events_o
);
    logic [7:0] left_r = 8'h00;
    initial events_o = '0;
    // levels drop back to quiet so no stale condition leaks into a count
    always_ff @(posedge core_clk_i) begin
        if (go_i) begin
            left_r <= len_i - 8'h01;
            events_o <= pattern_i;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end else begin
            events_o <= '0;
        end
    end
endmodule
`default_nettype wire

// *** verif/test_mioes_event_select.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_mioes_event_select;
    typedef struct {int sel; logic [15:0] ctl; logic [11:0] v; int len;
        logic [31:0] exp;} mioes_row_t;
    logic core_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, go = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, len = 8'h01;
    logic [31:0] wr_data_i = 32'h0, rd_data_o, a, b;
    mioes_pkg::mioes_events_t events, pat = '0;
    int errors = 0, check_count = 0;
    mioes_row_t rows [18];
    mioes_event_select mioes_event_select_inst (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .events_i(events),
        .rd_data_o(rd_data_o));
    mioes_event_source mioes_event_source_inst (.core_clk_i(core_clk_i),
        .go_i(go), .pattern_i(pat), .len_i(len), .events_o(events));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    // ----------------------------------------------------------------
    // bus and checking helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] ctl_a(int n);
        return mioes_pkg::CTL_BASE + 8'(n * 4);
    endfunction
    function automatic logic [7:0] lo_a(int n);
        return mioes_pkg::CTR_LO_BASE + 8'(n * 8);
    endfunction
    function automatic logic [7:0] hi_a(int n);
        return mioes_pkg::CTR_HI_BASE + 8'(n * 8);
    endfunction
    function automatic mioes_pkg::mioes_events_t mk(int s, logic [11:0] v);
        mioes_pkg::mioes_events_t e;
        e = '0;
        case (s)
            0: e.io_grant = v[5:0];
            1: e.io_refusal = v[2:0];
            2: e.io_busy = v[5:0];
            3: e.ded_take = v;
            4: e.ded_return = v;
            5: e.pool_ingress_ret = v[2:0];
            6: e.pool_ring_ret = v[5:0];
            7: e.pool_take = v;
            8: e.pool_wait = v;
            9: e.ded_arrival = v[3:0];
            default: e.fill_occ = {4{v[7:0]}};
        endcase
        return e;
    endfunction
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk_i);
        addr_i <= ad;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge core_clk_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic burst(input mioes_pkg::mioes_events_t p, input int n);
        @(posedge core_clk_i);
        pat <= p;
        len <= n[7:0];
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        repeat (n + 3) @(posedge core_clk_i);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        errors++;
        $display("watchdog expired");
        finish_test();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rows = '{'{0, 16'h2033, 12'h020, 3, 3}, '{0, 16'h0133, 12'h020, 3, 0},
            '{1, 16'h3834, 12'h007, 2, 2}, '{1, 16'h0834, 12'h001, 4, 4},
            '{2, 16'h0232, 12'h002, 5, 5}, '{3, 16'h8046, 12'h080, 2, 2},
            '{3, 16'h0847, 12'h800, 3, 3}, '{4, 16'h0119, 12'h001, 1, 1},
            '{4, 16'h011a, 12'h100, 2, 2}, '{5, 16'h0417, 12'h004, 3, 3},
            '{6, 16'h2044, 12'h020, 2, 2}, '{7, 16'h0140, 12'h001, 2, 2},
            '{7, 16'h0241, 12'h200, 1, 1}, '{8, 16'h404a, 12'h040, 3, 3},
            '{8, 16'h044b, 12'h400, 2, 2}, '{9, 16'h1016, 12'h008, 3, 3},
            '{10, 16'h1014, 12'h003, 2, 24}, '{10, 16'h0114, 12'h005, 2, 10}};
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(ctl_a(3), a);
        chk("ctl3 reset", 32'h0, a);
        rd(lo_a(3), a);
        chk("ctr3 reset", 32'h0, a);
        foreach (rows[i]) begin
            wr(lo_a(0), 32'h0);
            wr(hi_a(0), 32'h0);
            wr(ctl_a(0), {16'h0, rows[i].ctl});
            burst(mk(rows[i].sel, rows[i].v), rows[i].len);
            rd(lo_a(0), a);
            chk("ctr0", rows[i].exp, a);
            wr(ctl_a(0), 32'h0);
            $display("test row %0d done", i);
        end
        wr(ctl_a(1), 32'h1014);
        wr(ctl_a(2), 32'h1014);
        burst(mk(10, 12'h003), 2);
        rd(lo_a(1), a);
        chk("fill ctr1", 32'd24, a);
        rd(lo_a(2), a);
        chk("fill ctr2", 32'h0, a);
        $display("test fill counters done");
        wr(ctl_a(3), 32'h0001);
        rd(lo_a(3), a);
        rd(lo_a(3), b);
        chk("tick step", 32'd2, b - a);
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        ce_i <= 1'b1;
        rd(lo_a(3), a);
        chk("tick frozen", 32'd3, a - b);
        wr(lo_a(3), 32'hffffffff);
        rd(hi_a(3), a);
        chk("carry hi", 32'h1, a);
        $display("test cycle count done");
        wr(ctl_a(0), 32'hffffffff);
        rd(ctl_a(0), a);
        chk("ctl0 width", 32'h0000ffff, a);
        wr(hi_a(0), 32'hffffffff);
        rd(hi_a(0), a);
        chk("hi width", 32'h0000ffff, a);
        rd(8'hf0, a);
        chk("unmapped", mioes_pkg::UNMAPPED_READ, a);
        @(posedge core_clk_i);
        #1 chk("data gone", 32'h0, rd_data_o);
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(ctl_a(3), a);
        chk("ctl3 rereset", 32'h0, a);
        rd(hi_a(0), a);
        chk("hi0 rereset", 32'h0, a);
        $display("test registers and reset done");
        finish_test();
    end
endmodule
`default_nettype wire

// *** verilog/mioes_event_select.sv ***
// ----------------------------------------------------------------
// Summary of operation
// - code 0x1 counts every enabled clock on any counter 0..3
// - cycle count tracks enable with no extra delay, only a few cycles
// - code 0x33 counts io credits granted in response/bypass/standard class
// - each grant toward the io stack precedes its send; grants counted
// - grant mask bits 0..5: response, bypass, standard for port 0 and 1
// - code 0x34 counts refused credit attempts from data ring ingress
// - refusal mask bit 3 response, bit 4 bypass, bit 5 standard
// - code 0x32 counts cycles with at least one io credit busy
// - busy mask bits 0..5 select class per mesh port
// - code 0x46 counts dedicated peer takes, agents 0..3, mask bits 0..7
// - code 0x47 counts dedicated peer takes, agents 4..5, mask bits 0..3
// - code 0x19 counts dedicated peer returns, agents 0..3
// - code 0x1a counts dedicated peer returns, agents 4..5
// - code 0x17 counts pooled ingress returns, mask bits 0..2 agents
// - code 0x44 counts pooled ring returns, mask bits 0..5 agents
// - codes 0x40/0x41 count pooled peer takes, low and high agents
// - codes 0x4a/0x4b count pooled peer waits, low and high agents
// - code 0x14 occupancy only on counters 0 and 1, bit 4 all
// - four 48-bit counters, each with code and unit-mask control
// - arrival mask bits 0..3 select class, bit 4 selects all
// ----------------------------------------------------------------
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mioes_event_select (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire mioes_pkg::mioes_events_t events_i,
    output logic [31:0] rd_data_o
);

    // ----------------------------------------------------------------
    // event selection
    // ----------------------------------------------------------------
    function automatic logic [9:0] evt_incr(
        input mioes_pkg::mioes_ctl_t c,
        input mioes_pkg::mioes_events_t e,
        input logic fill_ok
    );
        logic [7:0] m;
        logic hit;
        logic [9:0] fill;
        logic [3:0] sel;
        m = c.umask;
        hit = 1'b0;
        fill = 10'h000;
        sel = m[3:0] | {4{m[mioes_pkg::ALL_BIT]}};
        // outside occupancy, any selected sub-condition gives one count per cycle
        case (c.code)
            mioes_pkg::EV_CYCLE: begin
                hit = 1'b1;
            end
            mioes_pkg::EV_IO_GRANT: begin
                hit = |(m[5:0] & e.io_grant);
            end
            mioes_pkg::EV_IO_REFUSAL: begin
                hit = |(m[5:mioes_pkg::REFUSAL_LSB] & e.io_refusal);
            end
            mioes_pkg::EV_IO_BUSY: begin
                hit = |(m[5:0] & e.io_busy);
            end
            mioes_pkg::EV_DED_TAKE_LO: begin
                hit = |(m & e.ded_take[7:0]);
            end
            mioes_pkg::EV_DED_TAKE_HI: begin
                hit = |(m[3:0] & e.ded_take[11:8]);
            end
            mioes_pkg::EV_DED_RETURN_LO: begin
                hit = |(m & e.ded_return[7:0]);
            end
            mioes_pkg::EV_DED_RETURN_HI: begin
                hit = |(m[3:0] & e.ded_return[11:8]);
            end
            mioes_pkg::EV_POOL_INGRESS_RET: begin
                hit = |(m[2:0] & e.pool_ingress_ret);
            end
            mioes_pkg::EV_POOL_RING_RET: begin
                hit = |(m[5:0] & e.pool_ring_ret);
            end
            mioes_pkg::EV_POOL_TAKE_LO: begin
                hit = |(m & e.pool_take[7:0]);
            end
            mioes_pkg::EV_POOL_TAKE_HI: begin
                hit = |(m[3:0] & e.pool_take[11:8]);
            end
            mioes_pkg::EV_POOL_WAIT_LO: begin
                hit = |(m & e.pool_wait[7:0]);
            end
            mioes_pkg::EV_POOL_WAIT_HI: begin
                hit = |(m[3:0] & e.pool_wait[11:8]);
            end
            mioes_pkg::EV_DED_ARRIVAL: begin
                hit = |(sel & e.ded_arrival);
            end
            mioes_pkg::EV_FILL: begin
                // occupancy adds the selected levels; refused off 0..1
                for (int i = 0; i < 4; i++) begin
                    if (fill_ok && sel[i]) begin
                        fill = fill + {2'b00, e.fill_occ[i]};
                    end
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return fill | {9'h000, hit};
    endfunction

    // ----------------------------------------------------------------
    // register file and counters
    // ----------------------------------------------------------------
    mioes_pkg::mioes_ctl_t ctl_r [mioes_pkg::NUM_CTR];
    logic [47:0] ctr_r [mioes_pkg::NUM_CTR];
    logic [31:0] rd_mux;
    logic [mioes_pkg::NUM_CTR-1:0] ctl_sel;
    logic [mioes_pkg::NUM_CTR-1:0] lo_sel;
    logic [mioes_pkg::NUM_CTR-1:0] hi_sel;
    logic [9:0] incr [mioes_pkg::NUM_CTR];
    logic [47:0] ctr_nxt [mioes_pkg::NUM_CTR];

    genvar g;
    generate
        for (g = 0; g < mioes_pkg::NUM_CTR; g++) begin : gen_ctr
            localparam logic [7:0] IDX = 8'(g);
            assign ctl_sel[g] = addr_i ==
                8'(mioes_pkg::CTL_BASE + IDX * mioes_pkg::CTL_STRIDE);
            assign lo_sel[g] = addr_i ==
                8'(mioes_pkg::CTR_LO_BASE + IDX * mioes_pkg::CTR_STRIDE);
            assign hi_sel[g] = addr_i ==
                8'(mioes_pkg::CTR_HI_BASE + IDX * mioes_pkg::CTR_STRIDE);
            assign incr[g] = evt_incr(ctl_r[g], events_i,
                g <= mioes_pkg::FILL_LAST_CTR);
            // counters wrap silently; software reads often enough
            assign ctr_nxt[g] = ctr_r[g] + {38'h0000000000, incr[g]};

            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    ctl_r[g] <= mioes_pkg::CTL_RESET;
                end else if (ce_i && wr_i && ctl_sel[g]) begin
                    ctl_r[g] <= wr_data_i[15:0];
                end
            end

            // a software write wins over a count in the same cycle
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    ctr_r[g] <= mioes_pkg::CTR_RESET;
                end else if (ce_i) begin
                    if (wr_i && lo_sel[g]) begin
                        ctr_r[g][31:0] <= wr_data_i;
                    end else if (wr_i && hi_sel[g]) begin
                        ctr_r[g][47:32] <= wr_data_i[15:0];
                    end else begin
                        ctr_r[g] <= ctr_nxt[g];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = mioes_pkg::UNMAPPED_READ;
        for (int i = 0; i < mioes_pkg::NUM_CTR; i++) begin
            if (ctl_sel[i]) begin
                rd_mux = {16'h0000, ctl_r[i]};
            end
            if (lo_sel[i]) begin
                rd_mux = ctr_r[i][31:0];
            end
            if (hi_sel[i]) begin
                rd_mux = {16'h0000, ctr_r[i][47:32]};
            end
        end
    end

    // read data stand until the next enabled clock after the strobe only
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rd_data_o <= mioes_pkg::UNMAPPED_READ;
        end else if (ce_i && rd_i) begin
            rd_data_o <= rd_mux;
        end else if (ce_i) begin
            rd_data_o <= mioes_pkg::UNMAPPED_READ;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_cycle_count_tick: assert property (
        (ce_i && !wr_i && ctl_r[2].code == mioes_pkg::EV_CYCLE) |=>
            ctr_r[2] == $past(ctr_r[2]) + 48'h000000000001
    ) else $error("cycle event did not add one");

    chk_cycle_two_edges: assert property (
        (ce_i && !wr_i && ctl_r[0].code == mioes_pkg::EV_CYCLE) [*2] |=>
            ctr_r[0] == $past(ctr_r[0], 2) + 48'h000000000002
    ) else $error("cycle event lost a tick");

    chk_grant_or_merge: assert property (
        (ce_i && !wr_i && ctl_r[0].code == mioes_pkg::EV_IO_GRANT &&
            |(ctl_r[0].umask[5:0] & events_i.io_grant)) |=>
            ctr_r[0] == $past(ctr_r[0]) + 48'h000000000001
    ) else $error("grant event count wrong");

    chk_refusal_mask: assert property (
        (ce_i && !wr_i && ctl_r[1].code == mioes_pkg::EV_IO_REFUSAL &&
            !(|(ctl_r[1].umask[5:3] & events_i.io_refusal))) |=>
            $stable(ctr_r[1])
    ) else $error("refusal counted while unselected");

    chk_busy_count: assert property (
        (ce_i && !wr_i && ctl_r[3].code == mioes_pkg::EV_IO_BUSY &&
            |(ctl_r[3].umask[5:0] & events_i.io_busy)) |=>
            ctr_r[3] == $past(ctr_r[3]) + 48'h000000000001
    ) else $error("busy cycle not counted");

    chk_fill_restrict: assert property (
        (!wr_i && ctl_r[2].code == mioes_pkg::EV_FILL) |=>
            $stable(ctr_r[2])
    ) else $error("occupancy counted on counter 2");

    chk_null_event: assert property (
        (!wr_i && ctl_r[1].code == mioes_pkg::EV_NULL) |=>
            $stable(ctr_r[1])
    ) else $error("null event changed a counter");

    chk_freeze_hold: assert property (
        !ce_i |=> $stable(ctr_r[0]) && $stable(ctr_r[3]) &&
            $stable(rd_data_o)
    ) else $error("state moved while clock enable low");

    chk_ctl_readback: assert property (
        (ce_i && rd_i && ctl_sel[0]) |=>
            rd_data_o == {16'h0000, $past(ctl_r[0])}
    ) else $error("control read data wrong");

endmodule
`default_nettype wire

// *** verilog/mioes_pkg.sv ***
`default_nettype none
package mioes_pkg;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CTR_W = 48;
    localparam int NUM_CTR = 4;
    localparam int FILL_W = 10;
    localparam logic [7:0] CTL_BASE = 8'h00;
    localparam logic [7:0] CTL_STRIDE = 8'h04;
    localparam logic [7:0] CTR_LO_BASE = 8'h10;
    localparam logic [7:0] CTR_HI_BASE = 8'h14;
    localparam logic [7:0] CTR_STRIDE = 8'h08;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [47:0] CTR_RESET = 48'h000000000000;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    // ----------------------------------------------------------------
    // event codes
    // ----------------------------------------------------------------
    localparam logic [7:0] EV_NULL = 8'h00;
    localparam logic [7:0] EV_CYCLE = 8'h01;
    localparam logic [7:0] EV_FILL = 8'h14;
    localparam logic [7:0] EV_DED_ARRIVAL = 8'h16;
    localparam logic [7:0] EV_POOL_INGRESS_RET = 8'h17;
    localparam logic [7:0] EV_DED_RETURN_LO = 8'h19;
    localparam logic [7:0] EV_DED_RETURN_HI = 8'h1a;
    localparam logic [7:0] EV_IO_BUSY = 8'h32;
    localparam logic [7:0] EV_IO_GRANT = 8'h33;
    localparam logic [7:0] EV_IO_REFUSAL = 8'h34;
    localparam logic [7:0] EV_POOL_TAKE_LO = 8'h40;
    localparam logic [7:0] EV_POOL_TAKE_HI = 8'h41;
    localparam logic [7:0] EV_POOL_RING_RET = 8'h44;
    localparam logic [7:0] EV_DED_TAKE_LO = 8'h46;
    localparam logic [7:0] EV_DED_TAKE_HI = 8'h47;
    localparam logic [7:0] EV_POOL_WAIT_LO = 8'h4a;
    localparam logic [7:0] EV_POOL_WAIT_HI = 8'h4b;

    // ----------------------------------------------------------------
    // unit-mask fields and counter restrictions
    // ----------------------------------------------------------------
    localparam int FILL_LAST_CTR = 1;
    localparam int ALL_BIT = 4;
    localparam int REFUSAL_LSB = 3;

    typedef struct packed {
        logic [7:0] umask;
        logic [7:0] code;
    } mioes_ctl_t;

    // io credit vectors: {std1,std0,byp1,byp0,rsp1,rsp0}
    // peer vectors: agent n at bits {2n+1 std, 2n bypass}
    // fill and arrival: {remote std, remote byp, local std, local byp}
    typedef struct packed {
        logic [5:0] io_grant;
        logic [2:0] io_refusal;
        logic [5:0] io_busy;
        logic [11:0] ded_take;
        logic [11:0] ded_return;
        logic [2:0] pool_ingress_ret;
        logic [5:0] pool_ring_ret;
        logic [11:0] pool_take;
        logic [11:0] pool_wait;
        logic [3:0] ded_arrival;
        logic [3:0][7:0] fill_occ;
    } mioes_events_t;

endpackage
`default_nettype wire
